//--- logic/ulf_core.sv
// Line format and modem control registers with serial and modem pin muxing.
// Assumes the host port, transmitter and receiver all run on clock.
`timescale 1ns/1ps
module ulf_core
   import ulf_pkg::*;
(
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       rst_n,
   // Host register port
   input  wire logic [2:0] addr,
   input  wire logic       ads_n,
   input  wire logic       wr_strobe,
   input  wire logic       rd_strobe,
   input  wire logic [7:0] wdata,
   output logic      [7:0] rdata,
   output logic            rdata_hit,
   // Shared address decode
   output logic            sel_buffer,
   output logic            sel_divisor_lo,
   output logic            sel_divisor_hi,
   output logic            sel_int_enable,
   // Transmitter side
   input  wire logic       tx_shift_out,
   input  wire logic       tx_active,
   input  wire logic [7:0] tx_word,
   output logic      [3:0] word_bits,
   output logic      [2:0] tx_stop_halves,
   output logic      [1:0] rx_stop_checks,
   output logic            parity_enable,
   output logic      [3:0] parity_slot,
   output logic            tx_parity_bit,
   // Receiver side
   input  wire logic [7:0] rx_word,
   input  wire logic       rx_parity_in,
   output logic            rx_serial,
   output logic            rx_parity_error,
   // Modem status view
   output logic            cts,
   output logic            dsr,
   output logic            ri,
   output logic            dcd,
   // Pins
   input  wire logic       sin,
   input  wire logic       cts_n,
   input  wire logic       dsr_n,
   input  wire logic       ri_n,
   input  wire logic       dcd_n,
   output logic            sout,
   output logic            dtr_n,
   output logic            rts_n,
   output logic            user_output_one_pin_n,
   output logic            user_output_two_pin_n
);

   ////////////////////////////////////////////////////////////////////////////
   // Parity of a word of the selected length
   function automatic logic parity_of(input logic [7:0] w, input logic [1:0] wl,
                                      input logic even, input logic stick);
      logic x;
      x = ^w[4:0];
      if (wl >= 2'h1) x = x ^ w[5];
      if (wl >= 2'h2) x = x ^ w[6];
      if (wl == 2'h3) x = x ^ w[7];
      if (stick) parity_of = ~even;
      else       parity_of = even ? x : ~x;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   logic [7:0] line_format_control_q, line_format_control_d;
   logic [7:0] modem_output_control_q, modem_output_control_d;
   logic [2:0] addr_q, addr_d;
   logic [7:0] rdata_q, rdata_d;
   logic       hit_q, hit_d;
   logic       sout_q, sout_d;
   logic       loopback_enable;
   logic       user_output_one_bit;
   logic       user_output_two_bit;
   ulf_wlen_t  wlen;

   always_comb begin
      addr_d                 = ads_n ? addr_q : addr;
      line_format_control_d  = line_format_control_q;
      modem_output_control_d = modem_output_control_q;
      if (wr_strobe && addr_q == ULF_ADDR_LINE) begin
         line_format_control_d = wdata;
      end
      if (wr_strobe && addr_q == ULF_ADDR_MODEM) begin
         modem_output_control_d = wdata & ULF_MC_RW_MASK;
      end
      rdata_d = 8'h00;
      hit_d   = 1'b0;
      if (rd_strobe && addr_q == ULF_ADDR_LINE) begin
         rdata_d = line_format_control_q;
         hit_d   = 1'b1;
      end
      if (rd_strobe && addr_q == ULF_ADDR_MODEM) begin
         rdata_d = modem_output_control_q & ULF_MC_RW_MASK;
         hit_d   = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         line_format_control_q  <= ULF_LF_RESET;
         modem_output_control_q <= ULF_MC_RESET;
         addr_q                 <= 3'h0;
         rdata_q                <= 8'h00;
         hit_q                  <= 1'b0;
      end else begin
         line_format_control_q  <= line_format_control_d;
         modem_output_control_q <= modem_output_control_d;
         addr_q                 <= addr_d;
         rdata_q                <= rdata_d;
         hit_q                  <= hit_d;
      end
   end

   assign rdata     = rdata_q;
   assign rdata_hit = hit_q;

   ////////////////////////////////////////////////////////////////////////////
   // Shared address decode
   always_comb begin
      sel_buffer     = (addr_q == ULF_ADDR_BUF_DLL) && !line_format_control_q[ULF_LF_BANK];
      sel_divisor_lo = (addr_q == ULF_ADDR_BUF_DLL) && line_format_control_q[ULF_LF_BANK];
      sel_divisor_hi = (addr_q == ULF_ADDR_IER_DLM) && line_format_control_q[ULF_LF_BANK];
      sel_int_enable = (addr_q == ULF_ADDR_IER_DLM) && !line_format_control_q[ULF_LF_BANK];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Frame format
   always_comb begin
      wlen           = ulf_wlen_t'(line_format_control_q[ULF_LF_WLEN_LSB +: 2]);
      word_bits      = ULF_MIN_WORD + {2'h0, wlen};
      parity_enable  = line_format_control_q[ULF_LF_PAR_EN];
      parity_slot    = word_bits;
      rx_stop_checks = ULF_RX_STOPS;
      if (!line_format_control_q[ULF_LF_STOP]) tx_stop_halves = ULF_STOP_ONE;
      else if (wlen == ULF_WL5)                tx_stop_halves = ULF_STOP_ONEH;
      else                                     tx_stop_halves = ULF_STOP_TWO;
      tx_parity_bit   = parity_of(tx_word, wlen, line_format_control_q[ULF_LF_EVEN],
                                  line_format_control_q[ULF_LF_STICK]);
      rx_parity_error = parity_enable &&
                        (rx_parity_in != parity_of(rx_word, wlen, line_format_control_q[ULF_LF_EVEN],
                                                   line_format_control_q[ULF_LF_STICK]));
   end

   ////////////////////////////////////////////////////////////////////////////
   // Serial line and loopback
   assign loopback_enable     = modem_output_control_q[ULF_MC_LOOPBACK];
   assign user_output_one_bit = modem_output_control_q[ULF_MC_USER_ONE];
   assign user_output_two_bit = modem_output_control_q[ULF_MC_USER_TWO];

   always_comb begin
      if (loopback_enable)                           sout_d = 1'b1;
      else if (line_format_control_q[ULF_LF_BREAK])  sout_d = 1'b0;
      else                                           sout_d = tx_shift_out;
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) sout_q <= 1'b1;
      else        sout_q <= sout_d;
   end

   assign sout      = sout_q;
   assign rx_serial = loopback_enable ? tx_shift_out : sin;

   always_comb begin
      if (loopback_enable) begin
         cts = modem_output_control_q[ULF_MC_SEND_REQ];
         dsr = modem_output_control_q[ULF_MC_TERM_READY];
         ri  = user_output_one_bit;
         dcd = user_output_two_bit;
      end else begin
         cts = ~cts_n;
         dsr = ~dsr_n;
         ri  = ~ri_n;
         dcd = ~dcd_n;
      end
   end

   assign dtr_n                 = ~modem_output_control_q[ULF_MC_TERM_READY];
   assign rts_n                 = ~modem_output_control_q[ULF_MC_SEND_REQ];
   assign user_output_one_pin_n = ~user_output_one_bit;
   assign user_output_two_pin_n = ~user_output_two_bit;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   sequence s_break_set;
      line_format_control_q[ULF_LF_BREAK] && !loopback_enable;
   endsequence

   a_break_low: assert property (s_break_set |=> !sout)
      else $error("break did not hold serial output low");
   a_loop_high: assert property (loopback_enable |=> sout)
      else $error("loopback did not hold serial output high");
   a_loop_rx: assert property (loopback_enable |-> rx_serial == tx_shift_out)
      else $error("loopback receive input not from transmitter");
   a_loop_modem: assert property (loopback_enable |-> cts == !rts_n && dsr == !dtr_n
                                  && ri == !user_output_one_pin_n && dcd == !user_output_two_pin_n)
      else $error("loopback modem mapping wrong");
   a_mc_upper_zero: assert property (hit_q && $past(addr_q) == ULF_ADDR_MODEM |-> rdata_q[7:5] == 3'h0)
      else $error("modem control upper bits not zero");
   a_stop_len: assert property (line_format_control_q[ULF_LF_STOP] && wlen != ULF_WL5
                                |-> tx_stop_halves == ULF_STOP_TWO)
      else $error("stop length wrong");
   a_word_len: assert property (word_bits == 4'h5 + {2'h0, line_format_control_q[1:0]})
      else $error("word length wrong");
   a_forced_even: assert property (line_format_control_q[ULF_LF_STICK] && line_format_control_q[ULF_LF_EVEN]
                                   |-> !tx_parity_bit)
      else $error("forced even parity not low");
   a_bank_sel: assert property (wr_strobe && addr_q == ULF_ADDR_LINE ##1 1'b1
                                |-> sel_divisor_lo == (addr_q == ULF_ADDR_BUF_DLL && $past(wdata[7])))
      else $error("bank select not following write");
   a_pin_wr: assert property (wr_strobe && addr_q == ULF_ADDR_MODEM |=> dtr_n == !$past(wdata[0]))
      else $error("terminal ready pin not complement of bit");

   ////////////////////////////////////////////////////////////////////////////
   // Register port checks
   sequence s_line_write;
      wr_strobe && addr_q == ULF_ADDR_LINE;
   endsequence

   sequence s_modem_write;
      wr_strobe && addr_q == ULF_ADDR_MODEM;
   endsequence

   sequence s_line_read;
      rd_strobe && addr_q == ULF_ADDR_LINE;
   endsequence

   sequence s_modem_read;
      rd_strobe && addr_q == ULF_ADDR_MODEM;
   endsequence

   a_format_write: assert property (s_line_write |=> line_format_control_q == $past(wdata))
      else $error("line format write not held");
   a_modem_write: assert property (s_modem_write |=> modem_output_control_q[4:0] == $past(wdata[4:0])
                                   && modem_output_control_q[7:5] == 3'h0)
      else $error("modem control write not held");
   a_line_read: assert property (s_line_read |=> rdata == $past(line_format_control_q) && rdata_hit)
      else $error("line format read back wrong");
   a_modem_read: assert property (s_modem_read |=> rdata[7:5] == 3'h0 && rdata_hit)
      else $error("modem control read upper bits not zero");
   a_user_pins: assert property (s_modem_write |=> rts_n == !$past(wdata[1])
                                 && user_output_one_pin_n == !$past(wdata[2])
                                 && user_output_two_pin_n == !$past(wdata[3]))
      else $error("modem output pins not complement of bits");
   a_bank_decode: assert property (line_format_control_q[ULF_LF_BANK] |-> !sel_buffer && !sel_int_enable)
      else $error("data buffers reachable with bank set");
   a_bank_clear: assert property (!line_format_control_q[ULF_LF_BANK] |-> !sel_divisor_lo && !sel_divisor_hi)
      else $error("divisor reachable with bank clear");

   ////////////////////////////////////////////////////////////////////////////
   // Frame format checks
   a_wl_eight: assert property (wlen == ULF_WL8 |-> word_bits == 4'h8)
      else $error("eight bit word length wrong");
   a_stop_one: assert property (!line_format_control_q[ULF_LF_STOP] |-> tx_stop_halves == 3'h2)
      else $error("single stop length wrong");
   a_stop_half: assert property (line_format_control_q[ULF_LF_STOP] && wlen == ULF_WL5
                                 |-> tx_stop_halves == 3'h3)
      else $error("one and a half stop length wrong");
   a_rx_stop: assert property (rx_stop_checks == 2'h1)
      else $error("receiver checks more than one stop bit");
   a_parity_off: assert property (!parity_enable |-> !rx_parity_error)
      else $error("parity error flagged with parity off");
   a_parity_slot: assert property (parity_slot == word_bits && word_bits >= 4'h5 && word_bits <= 4'h8)
      else $error("parity slot not after last data bit");
   a_even_sense: assert property (!line_format_control_q[ULF_LF_STICK] && line_format_control_q[ULF_LF_EVEN]
                                  && wlen == ULF_WL8 |-> tx_parity_bit == ^tx_word)
      else $error("even parity wrong");
   a_odd_sense: assert property (!line_format_control_q[ULF_LF_STICK] && !line_format_control_q[ULF_LF_EVEN]
                                 && wlen == ULF_WL8 |-> tx_parity_bit == !(^tx_word))
      else $error("odd parity wrong");
   a_forced_odd: assert property (line_format_control_q[ULF_LF_STICK] && !line_format_control_q[ULF_LF_EVEN]
                                  |-> tx_parity_bit)
      else $error("forced odd parity not high");
   a_forced_rx: assert property (parity_enable && line_format_control_q[ULF_LF_STICK]
                                 && line_format_control_q[ULF_LF_EVEN] |-> rx_parity_error == rx_parity_in)
      else $error("forced even parity check wrong");

   ////////////////////////////////////////////////////////////////////////////
   // Serial line and modem checks
   sequence s_break_clear;
      !line_format_control_q[ULF_LF_BREAK] && !loopback_enable;
   endsequence

   a_break_end: assert property (s_break_clear |=> sout == $past(tx_shift_out))
      else $error("serial output not back to transmitter after break");
   a_reset_idle: assert property ($rose(rst_n) |-> sout)
      else $error("serial output not idle after reset");
   a_loop_busy: assert property (loopback_enable && tx_active |=> sout)
      else $error("loopback let transmitter reach serial output");
   a_rx_direct: assert property (!loopback_enable |-> rx_serial == sin)
      else $error("receive input not from serial pin");
   a_modem_direct: assert property (!loopback_enable |-> cts == !cts_n && dsr == !dsr_n
                                    && ri == !ri_n && dcd == !dcd_n)
      else $error("modem status view not from pins");

endmodule // ulf_core

//--- logic/ulf_pkg.sv
// Constants for the line format and modem control block of a serial transceiver.
// Assumes a host register port with a three-bit address and an 8-bit data bus.
package ulf_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register addresses
   localparam logic [2:0] ULF_ADDR_BUF_DLL = 3'h0;
   localparam logic [2:0] ULF_ADDR_IER_DLM = 3'h1;
   localparam logic [2:0] ULF_ADDR_LINE   = 3'h3;
   localparam logic [2:0] ULF_ADDR_MODEM  = 3'h4;

   ////////////////////////////////////////////////////////////////////////////
   // Line format fields
   localparam int ULF_LF_WLEN_LSB = 0;
   localparam int ULF_LF_STOP     = 2;
   localparam int ULF_LF_PAR_EN   = 3;
   localparam int ULF_LF_EVEN     = 4;
   localparam int ULF_LF_STICK    = 5;
   localparam int ULF_LF_BREAK    = 6;
   localparam int ULF_LF_BANK     = 7;
   localparam logic [7:0] ULF_LF_RESET = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Modem control fields
   localparam int ULF_MC_TERM_READY = 0;
   localparam int ULF_MC_SEND_REQ   = 1;
   localparam int ULF_MC_USER_ONE   = 2;
   localparam int ULF_MC_USER_TWO   = 3;
   localparam int ULF_MC_LOOPBACK   = 4;
   localparam logic [7:0] ULF_MC_RESET    = 8'h00;
   localparam logic [7:0] ULF_MC_RW_MASK  = 8'h1f;

   ////////////////////////////////////////////////////////////////////////////
   // Frame figures, stop length in half bit times
   localparam logic [3:0] ULF_MIN_WORD   = 4'h5;
   localparam logic [2:0] ULF_STOP_ONE   = 3'h2;
   localparam logic [2:0] ULF_STOP_ONEH  = 3'h3;
   localparam logic [2:0] ULF_STOP_TWO   = 3'h4;
   localparam logic [1:0] ULF_RX_STOPS   = 2'h1;

   typedef enum logic [1:0] {
      ULF_WL5,
      ULF_WL6,
      ULF_WL7,
      ULF_WL8
   } ulf_wlen_t;

endpackage

//--- tb/ulf_modem_model.sv
// Modem and serial line model driving serial input and modem status pins.
// Assumes the bench hands it a fresh random pattern; lines toggle every cycle only while pattern bit 0 is set.
`timescale 1ns/1ps
module ulf_modem_model (
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       rst_n,
   // Pattern from bench
   input  wire logic [4:0] pattern,
   // Line pins
   output logic            sin,
   output logic            cts_n,
   output logic            dsr_n,
   output logic            ri_n,
   output logic            dcd_n
);
   logic [4:0] pins_q;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) pins_q <= 5'h1f;
      else pins_q <= pattern ^ {5{pins_q[0]}};
   end
   assign {dcd_n, ri_n, dsr_n, cts_n, sin} = pins_q;
endmodule // ulf_modem_model

//--- tb/testbench.sv
// Self-checking bench for the line format and modem control block.
// Assumes ulf_core and the modem model; host port driven 1 ns after each edge.
`timescale 1ns/1ps
module testbench;
   import ulf_pkg::*;
   logic       clock, rst_n, ads_n, wr_strobe, rd_strobe, tx_shift_out, tx_active, rx_parity_in;
   logic [2:0] addr, tx_stop_halves;
   logic [7:0] wdata, rdata, tx_word, rx_word, lf, mc;
   logic [3:0] word_bits, parity_slot;
   logic [1:0] rx_stop_checks;
   logic [4:0] pattern;
   logic       rdata_hit, sel_buffer, sel_divisor_lo, sel_divisor_hi, sel_int_enable;
   logic       parity_enable, tx_parity_bit, rx_serial, rx_parity_error, cts, dsr, ri, dcd;
   logic       sin, cts_n, dsr_n, ri_n, dcd_n, sout, dtr_n, rts_n;
   logic       user_output_one_pin_n, user_output_two_pin_n;
   int         mismatches, n_tests, seed_v;

   ulf_core dut (.clock, .rst_n, .addr, .ads_n, .wr_strobe, .rd_strobe, .wdata, .rdata, .rdata_hit,
      .sel_buffer, .sel_divisor_lo, .sel_divisor_hi, .sel_int_enable, .tx_shift_out, .tx_active,
      .tx_word, .word_bits, .tx_stop_halves, .rx_stop_checks, .parity_enable, .parity_slot,
      .tx_parity_bit, .rx_word, .rx_parity_in, .rx_serial, .rx_parity_error, .cts, .dsr, .ri,
      .dcd, .sin, .cts_n, .dsr_n, .ri_n, .dcd_n, .sout, .dtr_n, .rts_n, .user_output_one_pin_n,
      .user_output_two_pin_n);
   ulf_modem_model modem (.clock, .rst_n, .pattern, .sin, .cts_n, .dsr_n, .ri_n, .dcd_n);

   ////////////////////////////////////////////////////////////////////////////
   // Clock and watchdog
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   initial begin
      #200000;
      mismatches++;
      wrap_up();
   end

   ////////////////////////////////////////////////////////////////////////////
   // Expectations and host tasks
   function automatic logic exp_par(input logic [7:0] f, input logic [7:0] w);
      logic p;
      p = ^(w & (8'hff >> (2'h3 - f[1:0])));
      if (f[5]) return ~f[4];
      return f[4] ? p : ~p;
   endfunction
   function automatic logic [2:0] exp_stop(input logic [7:0] f);
      if (!f[2]) return 3'h2;
      return (f[1:0] == 2'h0) ? 3'h3 : 3'h4;
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic point(input logic [2:0] a);
      @(posedge clock);
      #1 addr = a;
      ads_n = 1'b0;
      @(posedge clock);
      #1 ads_n = 1'b1;
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      point(a);
      wr_strobe = 1'b1;
      wdata = d;
      @(posedge clock);
      #1 wr_strobe = 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic h);
      point(a);
      rd_strobe = 1'b1;
      @(posedge clock);
      #1 rd_strobe = 1'b0;
      chk(rdata, e);
      chk(rdata_hit, h);
   endtask
   task automatic wrap_up();
      if (mismatches == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      {ads_n, wr_strobe, rd_strobe, tx_shift_out, tx_active, rx_parity_in} = 6'h20;
      {addr, wdata, tx_word, rx_word, pattern} = '0;
      mismatches = 0;
      n_tests = 0;
      seed_v = $urandom(32'h6a9c);
      rst_n = 1'b0;
      repeat (4) @(posedge clock);
      #1 rst_n = 1'b1;
      chk(sout, 1'b1);
      chk({user_output_two_pin_n, user_output_one_pin_n, rts_n, dtr_n}, 4'hf);
      rd(3'h3, 8'h00, 1'b1);
      rd(3'h4, 8'h00, 1'b1);
      rd(3'h7, 8'h00, 1'b0);
      for (int i = 0; i < 24; i++) begin
         lf = 8'($urandom);
         if (i < 8) lf[5:3] = i[2:0];
         lf[6] = 1'b0;
         mc = 8'($urandom);
         {tx_word, rx_word, pattern} = 21'($urandom);
         {tx_shift_out, rx_parity_in, tx_active} = 3'($urandom);
         wr(3'h3, lf);
         chk(word_bits, 4'h5 + lf[1:0]);
         chk(tx_stop_halves, exp_stop(lf));
         chk(rx_stop_checks, 2'h1);
         chk(parity_enable, lf[3]);
         chk(parity_slot, 4'h5 + lf[1:0]);
         if (lf[3]) chk(tx_parity_bit, exp_par(lf, tx_word));
         chk(rx_parity_error, lf[3] && (rx_parity_in !== exp_par(lf, rx_word)));
         rd(3'h3, lf, 1'b1);
         point(3'h0);
         chk({sel_buffer, sel_divisor_lo}, {~lf[7], lf[7]});
         point(3'h1);
         chk({sel_int_enable, sel_divisor_hi}, {~lf[7], lf[7]});
         wr(3'h4, mc);
         chk({user_output_two_pin_n, user_output_one_pin_n, rts_n, dtr_n}, {~mc[3:0]});
         rd(3'h4, mc & 8'h1f, 1'b1);
         chk(rx_serial, mc[4] ? tx_shift_out : sin);
         chk({dcd, ri, dsr, cts}, mc[4] ? {mc[3], mc[2], mc[0], mc[1]} : {~dcd_n, ~ri_n, ~dsr_n, ~cts_n});
         chk(sout, mc[4] | tx_shift_out);
         wr(3'h3, lf | 8'h40);
         @(posedge clock);
         #1 chk(sout, mc[4]);
         wr(3'h3, lf);
         @(posedge clock);
         #1 chk(sout, mc[4] | tx_shift_out);
      end
      wr(3'h4, 8'h00);
      wr(3'h3, 8'h40);
      @(posedge clock);
      #1 chk(sout, 1'b0);
      rst_n = 1'b0;
      #1 chk(sout, 1'b1);
      chk({user_output_two_pin_n, user_output_one_pin_n, rts_n, dtr_n}, 4'hf);
      @(posedge clock);
      #1 rst_n = 1'b1;
      rd(3'h3, 8'h00, 1'b1);
      wrap_up();
   end
endmodule // testbench
